// >>> hw/asrp_port.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - with chip select low the serial output is actively driven.
// - with chip select high the serial output floats and clock and data input are ignored.
// - after a conversion the next result bit appears after every serial clock falling edge.
// - serial data input is captured on the first four serial clock rising edges of a frame only.
// - the serial output doubles as a conversion status indicator.
// - result bits appear on the serial output only in the data state.
// - sleep and rate options are accepted from the serial data input.
// - a four-bit word programs only when the first bit is 1 and the second 0, then rate, then sleep.
// - rate 0 gives the fast rate, 1 the slow calibrated rate; sleep 1 powers the reference down.
// - the result goes out most significant bit first, the sign valid on entering the data state.
// - the data state ends at the sixteenth falling edge or chip select rising, starting a conversion.
module asrp_port #(
	parameter int CONV_CYCLES = asrp_pkg::CONV_FAST_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	input wire logic sample_valid,
	input wire logic [asrp_pkg::RESULT_BITS-1:0] sample_data,
	output logic sample_ready,
	output logic converting,
	output logic reference_down,
	output logic rate_slow
);
	////////////////////////////////////////////////////////////////////////////////
	// link side, cleared by the frame's own chip select
	logic [asrp_pkg::RISE_W-1:0] rise_cnt_r, rise_cnt_nxt;
	logic [4:0] rise_gray_r, rise_gray_nxt;
	logic [asrp_pkg::PROG_BITS-1:0] word_r, word_nxt;
	logic [asrp_pkg::FALL_W-1:0] fall_cnt_r, fall_cnt_nxt;
	logic [4:0] fall_gray_r, fall_gray_nxt;

	// shift the program word on rising edges, only the first four count
	always_comb begin
		rise_cnt_nxt = rise_cnt_r;
		word_nxt = word_r;
		if (rise_cnt_r < asrp_pkg::PROG_RISES) begin
			rise_cnt_nxt = rise_cnt_r + 1'b1;
			word_nxt = {word_r[asrp_pkg::PROG_BITS-2:0], serial_in};
		end
		rise_gray_nxt = asrp_pkg::asrp_bin2gray(5'(rise_cnt_nxt));
	end

	always_ff @(posedge serial_clock or posedge chip_select_n) begin
		if (chip_select_n) begin
			rise_cnt_r <= '0;
			rise_gray_r <= '0;
			word_r <= '0;
		end else begin
			rise_cnt_r <= rise_cnt_nxt;
			rise_gray_r <= rise_gray_nxt;
			word_r <= word_nxt;
		end
	end

	// count falling edges up to the end of the frame
	always_comb begin
		fall_cnt_nxt = fall_cnt_r;
		if (fall_cnt_r < asrp_pkg::FRAME_FALLS) begin
			fall_cnt_nxt = fall_cnt_r + 1'b1;
		end
		fall_gray_nxt = asrp_pkg::asrp_bin2gray(fall_cnt_nxt);
	end

	always_ff @(negedge serial_clock or posedge chip_select_n) begin
		if (chip_select_n) begin
			fall_cnt_r <= '0;
			fall_gray_r <= '0;
		end else begin
			fall_cnt_r <= fall_cnt_nxt;
			fall_gray_r <= fall_gray_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// crossings into the system clock: level and gray counters, two flops each
	logic cs_s1_r, cs_s2_r;
	logic [4:0] rise_s1_r, rise_s2_r, fall_s1_r, fall_s2_r;
	logic [4:0] rise_b, fall_b;
	asrp_pkg::asrp_prog_t prog_word;

	always_ff @(posedge clock) begin
		if (reset) begin
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			rise_s1_r <= '0;
			rise_s2_r <= '0;
			fall_s1_r <= '0;
			fall_s2_r <= '0;
		end else begin
			cs_s1_r <= chip_select_n;
			cs_s2_r <= cs_s1_r;
			rise_s1_r <= rise_gray_r;
			rise_s2_r <= rise_s1_r;
			fall_s1_r <= fall_gray_r;
			fall_s2_r <= fall_s1_r;
		end
	end

	// word is frozen once four rises are seen, so it is stable when the count arrives
	always_comb begin
		rise_b = asrp_pkg::asrp_gray2bin(rise_s2_r);
		fall_b = asrp_pkg::asrp_gray2bin(fall_s2_r);
		prog_word = asrp_pkg::asrp_prog_t'(word_r);
	end

	////////////////////////////////////////////////////////////////////////////////
	// result buffer between the converter core and the port
	logic buf_valid, buf_take;
	logic [asrp_pkg::RESULT_BITS-1:0] buf_data;

	asrp_buffer #(
		.WIDTH(asrp_pkg::RESULT_BITS),
		.DEPTH(2)
	) u_buffer (
		.clock(clock),
		.reset(reset),
		.in_valid(sample_valid),
		.in_data(sample_data),
		.in_ready(sample_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(buf_take)
	);

	////////////////////////////////////////////////////////////////////////////////
	// converter cycle: convert, idle with result held, data in and out
	localparam logic [asrp_pkg::TIMER_W-1:0] FAST_C = asrp_pkg::TIMER_W'(CONV_CYCLES);
	localparam logic [asrp_pkg::TIMER_W-1:0] SLOW_C =
		asrp_pkg::TIMER_W'(CONV_CYCLES * asrp_pkg::CONV_SLOW_FACTOR);

	asrp_pkg::asrp_state_t state_r, state_nxt;
	logic [asrp_pkg::TIMER_W-1:0] timer_r, timer_nxt;
	logic [asrp_pkg::RESULT_BITS-1:0] result_r, result_nxt;
	logic rate_r, rate_nxt, sleep_r, sleep_nxt, prog_done_r, prog_done_nxt;
	logic sdo_nxt, oe_nxt, conv_nxt, refdn_nxt;
	logic [3:0] bit_sel;

	always_comb begin
		state_nxt = state_r;
		timer_nxt = timer_r;
		result_nxt = result_r;
		rate_nxt = rate_r;
		sleep_nxt = sleep_r;
		prog_done_nxt = prog_done_r;
		buf_take = 1'b0;
		case (state_r)
			asrp_pkg::ASRP_CONVERT: begin
				if (timer_r != '0) begin
					timer_nxt = timer_r - 1'b1;
				end else if (buf_valid) begin // stalls here until a sample is ready
					buf_take = 1'b1;
					result_nxt = buf_data;
					state_nxt = asrp_pkg::ASRP_IDLE;
				end
			end
			asrp_pkg::ASRP_IDLE: begin
				if (!cs_s2_r && fall_b == '0) begin
					state_nxt = asrp_pkg::ASRP_DATA;
				end
			end
			asrp_pkg::ASRP_DATA: begin
				if (rise_b >= 5'(asrp_pkg::PROG_RISES) && !prog_done_r) begin
					prog_done_nxt = 1'b1;
					if (prog_word.program_enable_first && !prog_word.program_enable_second) begin
						rate_nxt = prog_word.rate_select;
						sleep_nxt = prog_word.reference_sleep_select;
					end
				end
				if (cs_s2_r || fall_b == asrp_pkg::FRAME_FALLS) begin
					state_nxt = asrp_pkg::ASRP_CONVERT;
					timer_nxt = rate_nxt ? SLOW_C : FAST_C;
					prog_done_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = asrp_pkg::ASRP_CONVERT;
				timer_nxt = FAST_C;
			end
		endcase
		bit_sel = 4'hF - fall_b[3:0];
		// serial output: busy high, ready low, result bits only in data
		case (state_nxt)
			asrp_pkg::ASRP_CONVERT: sdo_nxt = 1'b1;
			asrp_pkg::ASRP_IDLE: sdo_nxt = 1'b0;
			asrp_pkg::ASRP_DATA: sdo_nxt = result_nxt[bit_sel];
			default: sdo_nxt = 1'b1;
		endcase
		oe_nxt = !cs_s2_r;
		conv_nxt = (state_nxt == asrp_pkg::ASRP_CONVERT);
		refdn_nxt = (state_nxt == asrp_pkg::ASRP_IDLE) && sleep_nxt && cs_s2_r;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= asrp_pkg::ASRP_CONVERT;
			timer_r <= FAST_C;
			result_r <= '0;
			rate_r <= asrp_pkg::RATE_RESET;
			sleep_r <= asrp_pkg::SLEEP_RESET;
			prog_done_r <= 1'b0;
			serial_out <= 1'b1;
			serial_out_oe <= 1'b0;
			converting <= 1'b1;
			reference_down <= 1'b0;
			rate_slow <= asrp_pkg::RATE_RESET;
		end else begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
			result_r <= result_nxt;
			rate_r <= rate_nxt;
			sleep_r <= sleep_nxt;
			prog_done_r <= prog_done_nxt;
			serial_out <= sdo_nxt;
			serial_out_oe <= oe_nxt;
			converting <= conv_nxt;
			reference_down <= refdn_nxt;
			rate_slow <= rate_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	logic prog_take;
	assign prog_take = state_r == asrp_pkg::ASRP_DATA && rise_b >= 5'(asrp_pkg::PROG_RISES)
		&& !prog_done_r;

	drive_on_select_a: assert property (@(posedge clock) disable iff (reset)
		!cs_s2_r |=> serial_out_oe) else $error("output not driven with select low");
	float_on_deselect_a: assert property (@(posedge clock) disable iff (reset)
		cs_s2_r |=> !serial_out_oe) else $error("output driven with select high");
	busy_shows_high_a: assert property (@(posedge clock) disable iff (reset)
		state_r == asrp_pkg::ASRP_CONVERT && timer_r > 1 |=> serial_out)
		else $error("busy not shown high");
	ready_shows_low_a: assert property (@(posedge clock) disable iff (reset)
		state_r == asrp_pkg::ASRP_IDLE ##1 state_r == asrp_pkg::ASRP_IDLE |-> !serial_out)
		else $error("ready not shown low");
	sign_first_a: assert property (@(posedge clock) disable iff (reset)
		$rose(state_r == asrp_pkg::ASRP_DATA) |-> serial_out == result_r[15])
		else $error("sign bit not first");
	bit_per_fall_a: assert property (@(posedge clock) disable iff (reset)
		state_r == asrp_pkg::ASRP_DATA && $past(state_r) == asrp_pkg::ASRP_DATA
		&& $past(fall_b) < 5'h10 |-> serial_out == result_r[4'hF - $past(fall_b[3:0])])
		else $error("wrong result bit");
	frame_end_a: assert property (@(posedge clock) disable iff (reset)
		state_r == asrp_pkg::ASRP_DATA && (cs_s2_r || fall_b == 5'h10)
		|=> state_r == asrp_pkg::ASRP_CONVERT && converting) else $error("frame did not end");
	program_accept_a: assert property (@(posedge clock) disable iff (reset)
		prog_take && prog_word[3:2] == 2'b10 |=> rate_r == $past(prog_word[1])
		&& sleep_r == $past(prog_word[0])) else $error("program word not applied");
	program_reject_a: assert property (@(posedge clock) disable iff (reset)
		prog_take && prog_word[3:2] != 2'b10 |=> $stable(rate_r) && $stable(sleep_r))
		else $error("program word wrongly applied");

	full_frame_c: cover property (@(posedge clock) disable iff (reset)
		state_r == asrp_pkg::ASRP_DATA && fall_b == 5'h10);
	abort_frame_c: cover property (@(posedge clock) disable iff (reset)
		state_r == asrp_pkg::ASRP_DATA && cs_s2_r && fall_b < 5'h10);
	program_c: cover property (@(posedge clock) disable iff (reset)
		prog_take && prog_word[3:2] == 2'b10);
	stall_c: cover property (@(posedge clock) disable iff (reset) !sample_ready);
endmodule
`default_nettype wire

// >>> hw/asrp_pkg.sv
package asrp_pkg;
	// result word and serial frame
	localparam int RESULT_BITS = 16;
	localparam int PROG_BITS = 4;
	localparam int FALL_W = 5;
	localparam int RISE_W = 3;
	localparam logic [4:0] FRAME_FALLS = 5'h10;
	localparam logic [2:0] PROG_RISES = 3'h4;

	// program word fields, first bit shifted in lands in the top position
	localparam int POS_EN_FIRST = 3;
	localparam int POS_EN_SECOND = 2;
	localparam int POS_RATE = 1;
	localparam int POS_SLEEP = 0;
	localparam logic RATE_RESET = 1'b0;
	localparam logic SLEEP_RESET = 1'b0;

	// conversion timing
	localparam real CLOCK_HZ = 25.0e6;
	localparam real T_CONV_MS = 16.6;
	localparam int CONV_FAST_CYCLES = int'($floor(T_CONV_MS * 1.0e-3 * CLOCK_HZ));
	localparam int CONV_SLOW_FACTOR = 2;
	localparam int TIMER_W = 21;

	typedef enum logic [1:0] {
		ASRP_CONVERT = 2'b00,
		ASRP_IDLE = 2'b01,
		ASRP_DATA = 2'b11
	} asrp_state_t;

	typedef struct packed {
		logic program_enable_first;
		logic program_enable_second;
		logic rate_select;
		logic reference_sleep_select;
	} asrp_prog_t;

	typedef struct packed {
		logic valid;
		logic [RESULT_BITS-1:0] data;
	} asrp_sample_t;

	function automatic logic [4:0] asrp_bin2gray(input logic [4:0] b);
		asrp_bin2gray = b ^ (b >> 1);
	endfunction

	function automatic logic [4:0] asrp_gray2bin(input logic [4:0] g);
		logic [4:0] b;
		b[4] = g[4];
		for (int i = 3; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		asrp_gray2bin = b;
	endfunction
endpackage

// >>> hw/asrp_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module asrp_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [PW:0] cnt_r, cnt_nxt;
	logic ready_r, ready_nxt;
	logic push, pop;

	// pointer and fill bookkeeping, ready is registered from the next fill
	always_comb begin
		push = in_valid && ready_r;
		pop = out_ready && (cnt_r != '0);
		wr_nxt = push ? ((wr_r == LAST_C) ? '0 : wr_r + 1'b1) : wr_r;
		rd_nxt = pop ? ((rd_r == LAST_C) ? '0 : rd_r + 1'b1) : rd_r;
		cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
		ready_nxt = (cnt_nxt != DEPTH_C);
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			ready_r <= 1'b1;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
			ready_r <= ready_nxt;
		end
	end

	// storage has no reset, only written entries are ever read
	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	assign in_ready = ready_r; // straight from a flop
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
endmodule
`default_nettype wire

// >>> verification/asrp_host.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// host master model: owns the serial clock, frames are started by the bench
module asrp_host (
	output logic serial_clock,
	output logic chip_select_n,
	output logic serial_in,
	input wire logic sdo_pin
);
	logic tick;

	// 64 ns base tick, phase unrelated to the system clock
	initial begin
		tick = 1'b0;
		serial_clock = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
		#7;
		forever #32 tick = ~tick;
	end

	// clocking with select high, which the port has to ignore
	task automatic noise();
		repeat (6) begin
			@(posedge tick);
			serial_clock <= ~serial_clock;
			serial_in <= ~serial_in;
		end
	endtask

	// one frame, half periods of five ticks (320 ns), bits latched on the rise
	task automatic frame(input logic [3:0] prog, input int nbits, input int settle,
		output logic [15:0] word, output logic busy, output logic tail);
		word = 16'h0000;
		@(posedge tick);
		chip_select_n <= 1'b0;
		repeat (4) @(posedge tick);
		busy = sdo_pin;
		// a busy level means the result is not ready yet, so let it finish
		if (busy === 1'b1) repeat (settle) @(posedge tick);
		for (int i = 0; i < nbits; i++) begin
			serial_in <= (i < 4) ? prog[3 - i] : ~serial_in;
			repeat (5) @(posedge tick);
			word[15 - i] = sdo_pin;
			serial_clock <= 1'b1;
			repeat (5) @(posedge tick);
			serial_clock <= 1'b0;
		end
		repeat (5) @(posedge tick);
		tail = sdo_pin;
		chip_select_n <= 1'b1;
		serial_in <= ~serial_in;
		repeat (4) @(posedge tick);
	endtask
endmodule
`default_nettype wire

// >>> verification/adc_serial_result_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module adc_serial_result_port_tb;
	localparam int CONV = 60;
	localparam int SETTLE = CONV * 2 * 40 / 64 + 20;
	logic clock, reset, sample_valid;
	logic [asrp_pkg::RESULT_BITS-1:0] sample_data;
	logic serial_out, serial_out_oe, sample_ready, converting, reference_down, rate_slow;
	wire logic serial_clock, chip_select_n, serial_in, sdo_pin;
	int error_cnt, cmp_count, run_len, last_len;
	logic [15:0] exp_q[$];
	logic [1:0] opts;
	logic [3:0] corner [5] = '{4'hA, 4'h9, 4'hF, 4'hB, 4'h3};

	// pin level seen by the host
	assign sdo_pin = serial_out_oe ? serial_out : 1'bz;

	asrp_port #(.CONV_CYCLES(CONV)) dut_u (
		.clock(clock), .reset(reset), .serial_clock(serial_clock),
		.chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .sample_valid(sample_valid), .sample_data(sample_data),
		.sample_ready(sample_ready), .converting(converting), .reference_down(reference_down),
		.rate_slow(rate_slow)
	);
	asrp_host host_u (.serial_clock(serial_clock), .chip_select_n(chip_select_n),
		.serial_in(serial_in), .sdo_pin(sdo_pin));

	////////////////////////////////////////////////////////////////////////////////
	// 25 MHz system clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// length of each conversion in system clocks
	always @(negedge clock) begin
		if (converting === 1'b1) begin
			run_len++;
		end else if (run_len > 0) begin
			last_len = run_len;
			run_len = 0;
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// offer one word and hold it until the buffer takes it
	task automatic push(input logic [15:0] w);
		@(negedge clock);
		sample_valid = 1'b1;
		sample_data = w;
		for (int n = 0; n < 3000 && sample_ready !== 1'b1; n++) @(negedge clock);
		check({15'h0000, sample_ready}, 16'h0001, "accept");
		@(negedge clock);
		sample_valid = 1'b0;
		sample_data = ~w;
		exp_q.push_back(w);
	endtask

	// options after a frame: only a full enable pattern in four bits programs
	function automatic logic [1:0] next_opts(input logic [3:0] p, input int nb,
		input logic [1:0] cur);
		if (nb >= asrp_pkg::PROG_BITS && p[asrp_pkg::POS_EN_FIRST] && !p[asrp_pkg::POS_EN_SECOND])
			return {p[asrp_pkg::POS_RATE], p[asrp_pkg::POS_SLEEP]};
		return cur;
	endfunction

	task automatic wrap_up();
		$display("errors %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		#3000000;
		error_cnt++;
		wrap_up();
	end

	// main sequence
	initial begin
		logic [15:0] w, exp, mask;
		logic [3:0] prog;
		logic b, t;
		int nb, lo;
		reset = 1'b1;
		sample_valid = 1'b0;
		sample_data = 16'h0000;
		error_cnt = 0;
		cmp_count = 0;
		run_len = 0;
		last_len = 0;
		opts = 2'b00;
		void'($urandom(63296));
		repeat (10) @(negedge clock);
		reset = 1'b0;
		@(negedge clock);
		check({11'h000, serial_out_oe, converting, rate_slow, reference_down, sample_ready},
			16'h0009, "reset");
		// two words fill the buffer, the third stalls until a conversion ends
		push(16'hA5C3);
		push(16'h5A3C);
		@(negedge clock);
		check({15'h0000, sample_ready}, 16'h0000, "full");
		push(16'($urandom));
		for (int i = 0; i < 16; i++) begin
			prog = (i < 5) ? corner[i] : 4'($urandom);
			nb = (i == 2) ? 5 : (i == 3) ? 3 : 16;
			host_u.noise();
			host_u.frame(prog, nb, SETTLE, w, b, t);
			exp = exp_q.pop_front();
			mask = ~(16'hFFFF >> nb);
			check(w & mask, exp & mask, "result");
			check({15'h0000, b}, {15'h0000, (i % 2 == 0 && i > 0) ? 1'b1 : exp[15]}, "status");
			check({15'h0000, t}, {15'h0000, (nb == 16) ? 1'b1 : exp[15 - nb]}, "tail");
			check({15'h0000, serial_out_oe}, 16'h0000, "float");
			opts = next_opts(prog, nb, opts);
			if (i > 0) push(16'($urandom));
			check({15'h0000, rate_slow}, {15'h0000, opts[1]}, "rate");
			// odd frames leave the conversion running so the next one sees busy
			if (i % 2 == 0) begin
				for (int n = 0; n < 3000 && converting !== 1'b0; n++) @(negedge clock);
				check({15'h0000, converting}, 16'h0000, "conversion end");
				@(negedge clock);
				check({15'h0000, reference_down}, {15'h0000, opts[0]}, "sleep");
				lo = CONV * (opts[1] ? asrp_pkg::CONV_SLOW_FACTOR : 1) - 1;
				check({15'h0000, last_len >= lo && last_len <= lo + 7}, 16'h0001, "length");
			end
		end
		wrap_up();
	end
endmodule
`default_nettype wire
